/* core/iets_consts.svh */
// constants of the interrupt and event transfer system
`ifndef IETS_CONSTS_SVH
`define IETS_CONSTS_SVH
`define IETS_NODE_BASE 12'h000
`define IETS_SEL_OFS 12'h100
`define IETS_CH_BASE 12'h140
`define IETS_CH_END 12'h1c0
`define IETS_ER_EDGE 12'h200
`define IETS_ER_ROUTE 12'h204
`define IETS_ER_GATE 12'h208
`define IETS_TRAP_OFS 12'h20c
`define IETS_STAT_OFS 12'h210
`define IETS_F_EN 6
`define IETS_F_REQ 7
`define IETS_F_XF 8
`define IETS_F_CH 9
`define IETS_F_WORD 8
`define IETS_F_INCS 9
`define IETS_F_INCD 10
`define IETS_F_CONT 11
`define IETS_VEC_NODE0 8'h10
`define IETS_VEC_SR0 8'h04
`define IETS_RESP_JC 7
`define IETS_RESP_NOJC 11
`endif

/* core/iets_pkg.sv */
// types of the interrupt and event transfer system
package iets_pkg;
   // per node control
   typedef struct packed {
      logic [2:0] chan;
      logic xf;
      logic req;
      logic en;
      logic [3:0] prio;
   } iets_node_t;
   // per transfer channel
   typedef struct packed {
      logic [23:0] src;
      logic [23:0] dst;
      logic [7:0] cnt;
      logic word;
      logic incS;
      logic incD;
      logic cont;
   } iets_chan_t;
   // one data move for the memory side
   typedef struct packed {
      logic [23:0] src;
      logic [23:0] dst;
      logic word;
   } iets_xfer_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SVC, ST_XFER} iets_state_t;
endpackage : iets_pkg

/* core/iets_top.sv */
// interrupt nodes, transfer channels, router and trap logic
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "iets_consts.svh"
module iets_top import iets_pkg::*; #(
   parameter int NODES = 46,
   parameter int CHANS = 8,
   parameter int SHARED = 4,
   parameter int ERCH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // request sources
   input wire logic [NODES-1:0] srcReq,
   input wire logic [3:0] srcShared,
   input wire logic [ERCH-1:0] erIn,
   input wire logic [2:0] esrPin,
   input wire logic [3:0] hwTrap,
   // cpu side
   input wire logic [3:0] cpuLevel,
   input wire logic jumpCache,
   input wire logic svcDone,
   input wire logic trapDone,
   input wire logic swTrapValid,
   input wire logic [7:0] swTrapNum,
   output logic intBranch,
   output logic [7:0] intVector,
   output logic trapBranch,
   output logic [7:0] trapVector,
   output logic cpuStall,
   output logic xferValid,
   output iets_xfer_t xfer,
   output logic [ERCH-1:0] erOut
);
   ////////////////////////////////////////////////////////////
   // storage
   iets_node_t node [NODES]; // node control words
   iets_chan_t chan [CHANS]; // transfer channels
   logic [NODES-1:0] zeroReq; // counter-expired requests
   logic [2*SHARED-1:0] srcSel; // shared node selects
   logic [2*ERCH-1:0] erEdge; // edge mode per input
   logic [4*ERCH-1:0] erRoute; // input mask per gate
   logic [11:0] erGate; // pattern and gate modes
   logic [ERCH-1:0] erPrev; // last router levels
   logic [2:0] esrPrev; // last pin levels
   logic [5:0] trapFlags; // sticky trap flags
   logic [5:0] trapPend; // traps awaiting entry
   logic trapActive; // trap service running
   logic [2:0] trapLvl; // index of running trap
   logic swPend; // software trap waiting
   logic [7:0] swNum; // its trap number
   iets_state_t state; // service sequencer
   logic [3:0] waitCnt; // response delay
   logic [7:0] pendVec; // vector being entered
   logic [5:0] xfNode; // node of current transfer
   logic [2:0] xfChan; // channel of current transfer
   // bus data phase
   logic wrEn;
   logic [11:0] wrAddr;

   ////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait, always okay
   logic acc;
   assign acc = hsel && hready && htrans[1];
   // capture write address for the data phase
   always_ff @(posedge clk) begin
      if (rst) begin
         wrEn <= 1'b0;
         wrAddr <= 12'h000;
      end else begin
         wrEn <= acc && hwrite;
         wrAddr <= haddr;
      end
   end
   // response flops
   always_ff @(posedge clk) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   // read data, registered at the address phase
   logic [31:0] rdVal;
   logic [5:0] rNode;
   logic [2:0] rCh;
   always_comb begin
      rNode = haddr[7:2];
      rCh = 3'((haddr - `IETS_CH_BASE) >> 4); // channel slot from its base
      rdVal = 32'h0000_0000;
      if (haddr < 12'(NODES * 4)) begin
         // fields at the positions that writes use
         rdVal = {20'h0, node[rNode].chan, node[rNode].xf, node[rNode].req,
                  node[rNode].en, 2'h0, node[rNode].prio};
      end else if (haddr == `IETS_SEL_OFS) begin
         rdVal = 32'(srcSel);
      end else if (haddr >= `IETS_CH_BASE && haddr < `IETS_CH_END) begin
         if (haddr[3:2] == 2'h0)
            rdVal = {8'h0, chan[rCh].src};
         else if (haddr[3:2] == 2'h1)
            rdVal = {8'h0, chan[rCh].dst};
         else if (haddr[3:2] == 2'h2)
            rdVal = {20'h0, chan[rCh].cont, chan[rCh].incD,
                     chan[rCh].incS, chan[rCh].word, chan[rCh].cnt};
      end else if (haddr == `IETS_ER_EDGE) begin
         rdVal = 32'(erEdge);
      end else if (haddr == `IETS_ER_ROUTE) begin
         rdVal = 32'(erRoute);
      end else if (haddr == `IETS_ER_GATE) begin
         rdVal = {20'h0, erGate};
      end else if (haddr == `IETS_TRAP_OFS) begin
         rdVal = {26'h0, trapFlags};
      end else if (haddr == `IETS_STAT_OFS) begin
         rdVal = {16'h0, trapActive, trapLvl, 2'(state), 2'h0, pendVec};
      end
   end
   always_ff @(posedge clk) begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (acc && !hwrite)
         hrdata <= rdVal;
   end

   ////////////////////////////////////////////////////////////
   // external request router
   logic [ERCH-1:0] erEvt;
   logic [ERCH-1:0] next_erOut;
   always_comb begin
      for (int i = 0; i < ERCH; i++) begin
         // rising, falling or both edges
         erEvt[i] = (erEdge[2*i] && erIn[i] && !erPrev[i]) ||
                    (erEdge[2*i+1] && !erIn[i] && erPrev[i]);
      end
      for (int k = 0; k < ERCH; k++) begin
         // combine routed events, then pattern filter
         logic hit;
         logic match;
         hit = |(erEvt & erRoute[4*k +: 4]);
         match = (erIn == erGate[3:0]);
         case (erGate[4+2*k +: 2])
            2'h0: next_erOut[k] = hit;
            2'h1: next_erOut[k] = hit && match;
            2'h2: next_erOut[k] = hit && !match;
            default: next_erOut[k] = 1'b0;
         endcase
      end
   end
   // router flops
   always_ff @(posedge clk) begin
      if (rst) begin
         erPrev <= erIn; // follow the pins: no false edge at release
         erOut <= '0;
      end else begin
         erPrev <= erIn;
         erOut <= next_erOut;
      end
   end

   ////////////////////////////////////////////////////////////
   // node request events and arbitration
   logic [NODES-1:0] nodeEvt;
   logic winValid;
   logic [5:0] winIdx;
   logic [3:0] winPri;
   always_comb begin
      for (int n = 0; n < NODES; n++) begin
         nodeEvt[n] = srcReq[n];
         if (n < ERCH)
            nodeEvt[n] = srcReq[n] || erOut[n];
         if (n >= NODES - SHARED)
            nodeEvt[n] = srcShared[srcSel[2*(n-NODES+SHARED) +: 2]];
      end
      winValid = 1'b0;
      winIdx = 6'h00;
      winPri = cpuLevel;
      for (int n = 0; n < NODES; n++) begin
         // strictly above the best so far; lowest index wins ties
         if (((node[n].req && node[n].en) || zeroReq[n]) &&
             node[n].prio > winPri) begin
            winValid = 1'b1;
            winIdx = 6'(n);
            winPri = node[n].prio;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // traps and system requests
   logic [5:0] trapEvt;
   logic trapGo;
   logic [2:0] trapIdx;
   always_comb begin
      trapEvt = {hwTrap,
                 (esrPin[1] && !esrPrev[1]) || (esrPin[2] && !esrPrev[2]),
                 esrPin[0] && !esrPrev[0]};
      trapGo = 1'b0;
      trapIdx = 3'h0;
      for (int t = 5; t >= 0; t--) begin
         // lower index is higher priority
         if (trapPend[t] && (!trapActive || 3'(t) < trapLvl)) begin
            trapGo = 1'b1;
            trapIdx = 3'(t);
         end
      end
   end
   // trap sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         esrPrev <= esrPin; // follow the pins: no false edge at release
         trapPend <= 6'h00;
         trapActive <= 1'b0;
         trapLvl <= 3'h0;
         trapBranch <= 1'b0;
         trapVector <= 8'h00;
      end else begin
         esrPrev <= esrPin;
         trapBranch <= trapGo;
         if (trapDone)
            trapActive <= 1'b0;
         if (trapGo) begin
            // immediate entry
            trapActive <= 1'b1;
            trapLvl <= trapIdx;
            trapVector <= (trapIdx < 3'h2) ? `IETS_VEC_SR0 + 8'(trapIdx)
                                           : 8'(trapIdx - 3'h2);
            trapPend <= (trapPend & ~(6'h01 << trapIdx)) | trapEvt;
         end else begin
            trapPend <= trapPend | trapEvt;
         end
      end
   end
   // trap flags: set wins over write-one-to-clear
   always_ff @(posedge clk) begin
      if (rst)
         trapFlags <= 6'h00;
      else if (wrEn && wrAddr == `IETS_TRAP_OFS)
         trapFlags <= (trapFlags & ~hwdata[5:0]) | trapEvt;
      else
         trapFlags <= trapFlags | trapEvt;
   end

   ////////////////////////////////////////////////////////////
   // service sequencer
   logic idleOk;
   logic grantAny;
   logic grantVec;
   logic [3:0] respLoad;
   assign idleOk = state == ST_IDLE && !trapActive && !trapGo;
   assign grantAny = idleOk && !swPend && winValid;
   assign grantVec = grantAny && (zeroReq[winIdx] || !node[winIdx].xf);
   assign respLoad = jumpCache ? 4'(`IETS_RESP_JC - 2) : 4'(`IETS_RESP_NOJC - 2);
   // software trap latch
   always_ff @(posedge clk) begin
      if (rst) begin
         swPend <= 1'b0;
         swNum <= 8'h00;
      end else if (swTrapValid && !swPend) begin
         swPend <= 1'b1;
         swNum <= swTrapNum;
      end else if (idleOk && swPend) begin
         swPend <= 1'b0;
      end
   end
   // state, delay and cpu outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         waitCnt <= 4'h0;
         pendVec <= 8'h00;
         intBranch <= 1'b0;
         intVector <= 8'h00;
         xferValid <= 1'b0;
         cpuStall <= 1'b0;
         xfer <= '0;
         xfNode <= 6'h00;
         xfChan <= 3'h0;
      end else begin
         intBranch <= 1'b0;
         xferValid <= 1'b0;
         cpuStall <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (idleOk && swPend) begin
                  state <= ST_WAIT;
                  waitCnt <= respLoad;
                  pendVec <= swNum;
               end else if (grantVec) begin
                  state <= ST_WAIT;
                  waitCnt <= respLoad;
                  pendVec <= `IETS_VEC_NODE0 + 8'(winIdx);
               end else if (grantAny) begin
                  // single stolen cycle
                  state <= ST_XFER;
                  xferValid <= 1'b1;
                  cpuStall <= 1'b1;
                  xfNode <= winIdx;
                  xfChan <= node[winIdx].chan;
                  xfer.src <= chan[node[winIdx].chan].src;
                  xfer.dst <= chan[node[winIdx].chan].dst;
                  xfer.word <= chan[node[winIdx].chan].word;
               end
            end
            ST_WAIT: begin
               // delay frozen while a trap runs
               if (!trapActive && !trapGo) begin
                  if (waitCnt == 4'h0) begin
                     intBranch <= 1'b1;
                     intVector <= pendVec;
                     state <= ST_SVC;
                  end else begin
                     waitCnt <= waitCnt - 4'h1;
                  end
               end
            end
            ST_SVC: begin
               if (svcDone)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // node control words and zero-count requests
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int n = 0; n < NODES; n++)
            node[n] <= '0;
         zeroReq <= '0;
         srcSel <= '0;
      end else begin
         for (int n = 0; n < NODES; n++) begin
            logic wr;
            wr = wrEn && wrAddr == `IETS_NODE_BASE + 12'(n * 4);
            if (wr) begin
               node[n].prio <= hwdata[3:0];
               node[n].en <= hwdata[`IETS_F_EN];
               node[n].req <= hwdata[`IETS_F_REQ];
               node[n].xf <= hwdata[`IETS_F_XF];
               node[n].chan <= hwdata[`IETS_F_CH +: 3];
            end else if (grantAny && winIdx == 6'(n)) begin
               node[n].req <= 1'b0;
            end
            if (nodeEvt[n])
               node[n].req <= 1'b1;
            if (grantAny && winIdx == 6'(n))
               zeroReq[n] <= 1'b0;
            if (state == ST_XFER && xfNode == 6'(n) && !chan[xfChan].cont &&
                chan[xfChan].cnt == 8'h01)
               zeroReq[n] <= 1'b1;
         end
         if (wrEn && wrAddr == `IETS_SEL_OFS)
            srcSel <= hwdata[2*SHARED-1:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // transfer channels: pointer and counter update
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < CHANS; c++)
            chan[c] <= '0;
      end else begin
         for (int c = 0; c < CHANS; c++) begin
            logic [11:0] base;
            logic [23:0] step;
            base = `IETS_CH_BASE + 12'(c * 16);
            step = chan[c].word ? 24'h000002 : 24'h000001;
            if (state == ST_XFER && xfChan == 3'(c)) begin
               if (chan[c].incS)
                  chan[c].src <= chan[c].src + step;
               if (chan[c].incD)
                  chan[c].dst <= chan[c].dst + step;
               if (!chan[c].cont)
                  chan[c].cnt <= chan[c].cnt - 8'h01;
            end
            if (wrEn && wrAddr == base)
               chan[c].src <= hwdata[23:0];
            if (wrEn && wrAddr == base + 12'h004)
               chan[c].dst <= hwdata[23:0];
            if (wrEn && wrAddr == base + 12'h008) begin
               chan[c].cnt <= hwdata[7:0];
               chan[c].word <= hwdata[`IETS_F_WORD];
               chan[c].incS <= hwdata[`IETS_F_INCS];
               chan[c].incD <= hwdata[`IETS_F_INCD];
               chan[c].cont <= hwdata[`IETS_F_CONT];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // router configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         erEdge <= '0;
         erRoute <= '0;
         erGate <= 12'h000;
      end else if (wrEn) begin
         if (wrAddr == `IETS_ER_EDGE)
            erEdge <= hwdata[2*ERCH-1:0];
         else if (wrAddr == `IETS_ER_ROUTE)
            erRoute <= hwdata[4*ERCH-1:0];
         else if (wrAddr == `IETS_ER_GATE)
            erGate <= hwdata[11:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [NODES-1:0] reqBits;
   always_comb
      for (int n = 0; n < NODES; n++)
         reqBits[n] = node[n].req;
   a_xfer_one_cycle: assert property (xferValid |-> cpuStall ##1 !xferValid)
      else $error("transfer stole more than one cycle");
   a_resp_time_jc: assert property ((grantVec && jumpCache) ##1
      (!trapActive && !trapGo)[*6] |=> intBranch)
      else $error("jump cache response not 7 cycles");
   a_grant_clears_flag: assert property (grantAny && !nodeEvt[winIdx] && !wrEn
      |=> !reqBits[$past(winIdx)])
      else $error("granted request flag not cleared");
   a_count_dec: assert property (state == ST_XFER && !chan[xfChan].cont && !wrEn
      |=> chan[$past(xfChan)].cnt == $past(chan[xfChan].cnt) - 8'h01)
      else $error("transfer counter not decremented");
   a_zero_raises: assert property (state == ST_XFER && !chan[xfChan].cont &&
      chan[xfChan].cnt == 8'h01 |=> zeroReq[$past(xfNode)])
      else $error("zero count did not raise interrupt");
   a_trap_flag_set: assert property (|hwTrap |=>
      (trapFlags[5:2] & $past(hwTrap)) == $past(hwTrap))
      else $error("trap flag not set");
   a_trap_blocks: assert property (trapActive |-> !intBranch && !xferValid)
      else $error("service ran inside trap");
   a_esr_request: assert property ($rose(esrPin[0]) |=> trapFlags[0] ##1 trapPend[0]
      || trapActive)
      else $error("service pin did not raise request");
   a_trap_entry: assert property (trapGo |=> trapBranch && trapActive)
      else $error("trap not entered at once");
   c_transfer: cover property (xferValid);
   c_vectored: cover property (intBranch ##1 state == ST_SVC);
   c_nested_trap: cover property (trapActive && trapGo);
   c_resp_nojc: cover property (grantVec && !jumpCache ##[10:12] intBranch);
endmodule : iets_top

/* tb/iets_cpu_model.sv */
// cpu stand-in that closes vectored and trap services after a delay
`timescale 1ns/1ps
module iets_cpu_model #(
   parameter int SVC_WAIT = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // branch pulses from the block
   input wire logic intBranch,
   input wire logic trapBranch,
   // completion pulses back to the block
   output logic svcDone,
   output logic trapDone
);
   int intCnt; // handler cycles left, vectored
   int trapCnt; // handler cycles left, trap
   ////////////////////////////////////////////////////////////
   // run each handler, then pulse its done line once
   always_ff @(posedge clk) begin
      if (rst) begin
         intCnt <= 0;
         trapCnt <= 0;
         svcDone <= 1'b0;
         trapDone <= 1'b0;
      end else begin
         svcDone <= !intBranch && intCnt == 1;
         trapDone <= !trapBranch && trapCnt == 1;
         intCnt <= intBranch ? SVC_WAIT : (intCnt > 0 ? intCnt - 1 : 0);
         trapCnt <= trapBranch ? SVC_WAIT : (trapCnt > 0 ? trapCnt - 1 : 0);
      end
   end
endmodule : iets_cpu_model

/* tb/test_interrupt_and_event_transfer_system.sv */
// self-checking bench for the interrupt and event transfer system
`timescale 1ns/1ps
`include "iets_consts.svh"
module test_interrupt_and_event_transfer_system import iets_pkg::*;;
   ////////////////////////////////////////////////////////////
   // bench signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, jumpCache, svcDone, trapDone, swTrapValid;
   logic intBranch, trapBranch, cpuStall, xferValid;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic [31:0] cfgE, cfgR, cfgG; // router setup: edges, routes, gates
   logic [45:0] srcReq;
   logic [3:0] erIn, hwTrap, cpuLevel, erOut, pa, pb, srcShared;
   logic [2:0] esrPin;
   logic [7:0] swTrapNum, intVector, trapVector;
   iets_xfer_t xfer;
   int badCount, numChecks, n, k, b;
   int pend[46]; // reference model: pending priority per node, 0 = none
   wire logic [2:0] ev = {trapBranch, xferValid, intBranch};
   always #20 clk = ~clk;
   iets_top iets_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .srcReq(srcReq), .srcShared(srcShared), .erIn(erIn),
      .esrPin(esrPin), .hwTrap(hwTrap), .cpuLevel(cpuLevel), .jumpCache(jumpCache),
      .svcDone(svcDone), .trapDone(trapDone), .swTrapValid(swTrapValid),
      .swTrapNum(swTrapNum), .intBranch(intBranch), .intVector(intVector),
      .trapBranch(trapBranch), .trapVector(trapVector), .cpuStall(cpuStall),
      .xferValid(xferValid), .xfer(xfer), .erOut(erOut));
   iets_cpu_model #(.SVC_WAIT(3)) iets_cpu_model_inst (.clk(clk), .rst(rst),
      .intBranch(intBranch), .trapBranch(trapBranch), .svcDone(svcDone), .trapDone(trapDone));
   ////////////////////////////////////////////////////////////
   // compare, verdict and bus tasks
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // one edge, then hold until hready is seen high
   task automatic hold();
      int i;
      @(posedge clk);
      for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge clk);
      if (hreadyout !== 1'b1) begin
         badCount++;
         give_verdict();
      end
   endtask : hold
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hold();
      htrans <= 2'b00;
      hwdata <= d;
      hold();
      rd = hrdata;
   endtask : ahb
   // count edges until the chosen event pulse shows, bounded
   task automatic waitEv(input int which);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ev[which] !== 1'b1 && n < 80);
      if (ev[which] !== 1'b1) begin
         badCount++;
         give_verdict();
      end
   endtask : waitEv
   // highest pending priority above the level, lowest index on ties
   function automatic int winner(input int lvl);
      int w;
      w = -1;
      foreach (pend[i]) if (pend[i] > lvl && (w < 0 || pend[i] > pend[w])) w = i;
      return w;
   endfunction : winner
   // gate outputs expected from old and new router levels
   function automatic logic [3:0] gates(input logic [3:0] p, input logic [3:0] c);
      logic [3:0] ev;
      logic [3:0] o;
      logic [1:0] m;
      o = 4'h0;
      for (int i = 0; i < 4; i++)
         ev[i] = (cfgE[2 * i] && c[i] && !p[i]) || (cfgE[2 * i + 1] && p[i] && !c[i]);
      for (int g = 0; g < 4; g++) begin
         m = cfgG[4 + 2 * g +: 2];
         if (|(ev & cfgR[4 * g +: 4]))
            o[g] = m == 2'h0 || (m == 2'h1 && c == cfgG[3:0]) || (m == 2'h2 && c != cfgG[3:0]);
      end
      return o;
   endfunction : gates
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {hsel, hwrite, haddr, htrans, hwdata, srcReq, erIn, hwTrap, srcShared, esrPin} = '0;
      {cpuLevel, jumpCache, swTrapValid, swTrapNum, badCount, numChecks} = '0;
      foreach (pend[i]) pend[i] = 0;
      k = $urandom(32'h3ee8);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, `IETS_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      chk({intBranch, trapBranch, xferValid, cpuStall, hresp}, 32'h0);
      // software-set flag, response with and without jump cache
      for (k = 0; k < 2; k++) begin
         jumpCache <= k[0];
         pa = 4'(1 + $urandom % 15);
         ahb(1'b1, 12'(4 * (6 + k)), {24'h0, 4'hc, pa});
         waitEv(0);
         chk(n, k ? `IETS_RESP_JC : `IETS_RESP_NOJC);
         chk(intVector, `IETS_VEC_NODE0 + 8'(6 + k));
         ahb(1'b0, 12'(4 * (6 + k)), 32'h0);
         chk(rd, {24'h0, 4'h4, pa});
         repeat (8) @(posedge clk);
      end
      // two nodes held back by cpu level, then granted in priority order
      cpuLevel <= 4'hf;
      pa = 4'(1 + $urandom % 15);
      pb = 4'(1 + $urandom % 15);
      ahb(1'b1, 12'd40, {24'h0, 4'hc, pa});
      ahb(1'b1, 12'd44, {24'h0, 4'hc, pb});
      pend[10] = pa;
      pend[11] = pb;
      repeat (12) @(posedge clk);
      chk(intBranch, 1'b0);
      cpuLevel <= 4'h0;
      for (k = 0; k < 2; k++) begin
         b = winner(0);
         waitEv(0);
         chk(intVector, `IETS_VEC_NODE0 + 8'(b));
         pend[b] = 0;
      end
      repeat (8) @(posedge clk);
      // channel 2: two word moves, source pointer only, then zero service
      ahb(1'b1, `IETS_CH_BASE + 12'h20, 32'h1000);
      ahb(1'b1, `IETS_CH_BASE + 12'h24, 32'h2000);
      ahb(1'b1, `IETS_CH_BASE + 12'h28, 32'h302);
      ahb(1'b1, 12'd80, 32'h545);
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         srcReq[20] <= 1'b1;
         @(posedge clk);
         srcReq[20] <= 1'b0;
         waitEv(1);
         chk(cpuStall, 1'b1);
         chk(intBranch, 1'b0);
         chk(xfer, {24'h1000 + 24'(2 * (k % 2) + 4 * (k / 2)), 24'h2000, k < 2});
         @(posedge clk);
         #1;
         chk({cpuStall, xferValid}, 32'h0);
         if (k == 1) begin
            waitEv(0);
            chk(intVector, `IETS_VEC_NODE0 + 8'd20);
            ahb(1'b0, `IETS_CH_BASE + 12'h28, 32'h0);
            chk(rd, 32'h300);
            repeat (8) @(posedge clk);
            ahb(1'b1, `IETS_CH_BASE + 12'h28, 32'h801);
         end
      end
      ahb(1'b0, `IETS_CH_BASE + 12'h28, 32'h0);
      chk(rd, 32'h801);
      ahb(1'b0, `IETS_CH_BASE + 12'h20, 32'h0);
      chk(rd, 32'h1004);
      // router: random setup and inputs against the gate model
      cfgE = $urandom;
      cfgR = $urandom;
      cfgG = $urandom;
      ahb(1'b1, `IETS_ER_EDGE, cfgE);
      ahb(1'b1, `IETS_ER_ROUTE, cfgR);
      ahb(1'b1, `IETS_ER_GATE, cfgG);
      for (k = 0; k < 32; k++) begin
         pa = erIn;
         pb = 4'($urandom);
         erIn <= pb;
         @(posedge clk);
         #1;
         chk(erOut, gates(pa, pb));
         @(posedge clk);
      end
      // shared node 43 picks shared source 2 alone
      ahb(1'b1, `IETS_SEL_OFS, 32'h8);
      for (k = 1; k < 3; k++) begin
         @(posedge clk);
         srcShared <= 4'(1 << k);
         @(posedge clk);
         srcShared <= 4'h0;
         ahb(1'b0, 12'd172, 32'h0);
         chk(rd, k == 2 ? 32'h80 : 32'h0);
      end
      // hardware trap: vector, flag, write-one-to-clear
      @(posedge clk);
      hwTrap <= 4'h4;
      @(posedge clk);
      hwTrap <= 4'h0;
      waitEv(2);
      chk(trapVector, 8'h2);
      ahb(1'b0, `IETS_TRAP_OFS, 32'h0);
      chk(rd, 32'h10);
      ahb(1'b1, `IETS_TRAP_OFS, 32'h10);
      ahb(1'b0, `IETS_TRAP_OFS, 32'h0);
      chk(rd, 32'h0);
      // service pins: pin 0 raises request zero, pin 2 request one
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         esrPin <= k ? 3'h4 : 3'h1;
         @(posedge clk);
         esrPin <= 3'h0;
         waitEv(2);
         chk(trapVector, `IETS_VEC_SR0 + 8'(k));
      end
      ahb(1'b0, `IETS_TRAP_OFS, 32'h0);
      chk(rd, 32'h3);
      // software trap with a random number
      @(posedge clk);
      swTrapValid <= 1'b1;
      swTrapNum <= 8'($urandom);
      @(posedge clk);
      swTrapValid <= 1'b0;
      waitEv(0);
      chk(intVector, swTrapNum);
      ahb(1'b0, 12'h3fc, 32'h0);
      chk(rd, 32'h0);
      give_verdict();
   end
endmodule : test_interrupt_and_event_transfer_system
